/* hdl/ptl_test_top.sv */
// Frame generator, frame check counters and loopback paths of one port
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Function
// R1: Generator enabled replaces MAC transmit data
// R2: MAC receive stays on unless disable bit
// R3: Run bit starts configured frame generation
// R4: Non-continuous run stops after frame limit
// R5: Generator paces bytes at every speed
// R6: 14-bit good and 8-bit bad counters
// R7: Received frame sets flag, one counter
// R8: Counter read returns value then clears
// R9: Good counter wraps at 10000
// R10: Bad counter saturates at 255
// R11: Counters work in every media mode
// R12: Far-end loopback echoes media receive
// R13: Far-end loopback still feeds MAC receive
// R14: Far-end loopback discards MAC transmit
// R15: Near-end loopback returns MAC transmit
// R16: Near-end loopback keeps medium silent
// R17: Connector loopback uses normal speed setup
// R18: Software sets connector before pair swap
// R19: Near-end wins over far-end loopback
module ptl_test_top
   import ptl_pkg::*;
#(
   parameter int FRAME_LIMIT = FRAME_LIMIT_DEF
) (
   input  wire logic          clk_sys_in,
   input  wire logic          rst_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   output logic [DW-1:0]      rdata_out,
   output logic               irq_out,
   input  wire logic [7:0]    mac_txd_in,
   input  wire logic          mac_txen_in,
   output logic [7:0]         mac_rxd_out,
   output logic               mac_rxdv_out,
   input  wire logic [7:0]    med_rxd_in,
   input  wire logic          med_rxdv_in,
   input  wire logic          med_frame_end_in,
   input  wire logic          med_crc_ok_in,
   output logic [7:0]         med_txd_out,
   output logic               med_txen_out,
   output logic [1:0]         speed_out,
   output logic               conn_lb_out,
   output logic               swap_dis_out
);
   if (FRAME_LIMIT < 1 || FRAME_LIMIT > 33554431) begin : g_limit_chk
      $error("FRAME_LIMIT out of range");
   end

   logic [15:0] ctrl_q;
   logic        run_q;
   logic [10:0] len_q;
   logic [7:0]  gap_q;
   logic [15:0] addr_q;
   logic [8:0]  pat_q;
   logic [13:0] good_q;
   logic [7:0]  bad_q;
   logic        rxflag_q;
   logic [IRQ_W-1:0] istat_q;
   logic [IRQ_W-1:0] imask_q;
   logic [24:0] frames_q;
   logic [7:0]  pace_q;
   ptl_gen_e    st_q, st_d;
   logic [10:0] idx_q, idx_d;

   wire gen_en   = ctrl_q[GEN_EN_BIT];
   wire cont     = ctrl_q[CONT_BIT];
   wire rx_dis   = ctrl_q[RXDIS_BIT];
   wire near_lb  = ctrl_q[NEAR_BIT];
   wire far_lb   = ctrl_q[FAR_BIT];
   wire [1:0] spd = ctrl_q[SPD_LSB +: 2];

   // Bus decode
   wire wr_ctrl  = wr_in && addr_in == CTRL_OFS;
   wire wr_len   = wr_in && addr_in == LEN_OFS;
   wire wr_gap   = wr_in && addr_in == GAP_OFS;
   wire wr_addr  = wr_in && addr_in == ADDR_OFS;
   wire wr_pat   = wr_in && addr_in == PAT_OFS;
   wire wr_imask = wr_in && addr_in == IMASK_OFS;
   wire rd_good  = rd_in && addr_in == GOOD_OFS;
   wire rd_bad   = rd_in && addr_in == BAD_OFS;
   wire rd_istat = rd_in && addr_in == ISTAT_OFS;

   // Byte pacing per line speed
   wire [7:0] pace_lim = (spd == SPD_10)  ? 8'(CYC_10) :
                         (spd == SPD_100) ? 8'(CYC_100) :
                                            8'(CYC_1000);
   wire tick = pace_q >= pace_lim - 8'h01; // R5

   // Zero length or gap is served as one byte
   wire [10:0] len_m1 = (len_q == 11'h000) ? 11'h000 : len_q - 11'h001;
   wire [10:0] gap_m1 = (gap_q == 8'h00) ? 11'h000 :
                        {3'h0, gap_q} - 11'h001;

   logic frame_done;
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      frame_done = 1'b0;
      unique case (st_q)
         GEN_IDLE: begin
            if (gen_en && run_q) begin // R3
               st_d = GEN_HDR;
               idx_d = 11'h000;
            end
         end
         GEN_HDR: begin
            if (tick) begin
               idx_d = (idx_q == HDR_LEN - 11'h001) ? 11'h000
                                                    : idx_q + 11'h001;
               if (idx_q == HDR_LEN - 11'h001) begin
                  st_d = GEN_PAY;
               end
            end
         end
         GEN_PAY: begin
            if (tick) begin
               idx_d = (idx_q == len_m1) ? 11'h000 : idx_q + 11'h001;
               if (idx_q == len_m1) begin
                  st_d = GEN_FCS;
               end
            end
         end
         GEN_FCS: begin
            if (tick) begin
               idx_d = (idx_q == FCS_LEN - 11'h001) ? 11'h000
                                                    : idx_q + 11'h001;
               if (idx_q == FCS_LEN - 11'h001) begin
                  st_d = GEN_GAP;
                  frame_done = 1'b1;
               end
            end
         end
         GEN_GAP: begin
            if (tick) begin
               idx_d = idx_q + 11'h001;
               if (idx_q == gap_m1) begin
                  st_d = GEN_IDLE;
               end
            end
         end
      endcase
      if (!gen_en) begin
         st_d = GEN_IDLE;
      end
   end

   // Generated byte
   wire gen_txen = st_q == GEN_HDR || st_q == GEN_PAY || st_q == GEN_FCS;
   wire [7:0] fcs_b = pat_q[PAT_BAD_BIT] ? ~FCS_BYTE : FCS_BYTE;
   wire [7:0] gen_txd = (st_q == GEN_HDR) ?
                           ((idx_q < ADDR_LEN) ? addr_q[15:8] : addr_q[7:0]) :
                        (st_q == GEN_PAY) ? pat_q[7:0] :
                        (st_q == GEN_FCS) ? fcs_b : 8'h00;

   wire auto_stop = frame_done && !cont &&
                    frames_q == 25'(FRAME_LIMIT - 1);
   wire run_start = wr_ctrl && wdata_in[GEN_RUN_BIT] && !run_q;

   // Transmit and receive path selection
   wire [7:0] tx_d = near_lb ? 8'h00 :              // R16 R19
                     far_lb  ? med_rxd_in :         // R12 R14
                     gen_en  ? gen_txd : mac_txd_in; // R1
   wire       tx_en = near_lb ? 1'b0 :
                      far_lb  ? med_rxdv_in :
                      gen_en  ? gen_txen : mac_txen_in;
   wire [7:0] rx_d = near_lb ? mac_txd_in :          // R15
                     rx_dis  ? 8'h00 : med_rxd_in;   // R2 R13
   wire       rx_en = near_lb ? mac_txen_in :
                      rx_dis  ? 1'b0 : med_rxdv_in;

   // Frame check events, any media mode
   wire good_evt = med_frame_end_in && med_crc_ok_in;   // R11
   wire bad_evt  = med_frame_end_in && !med_crc_ok_in;
   wire [13:0] good_base = rd_good ? 14'h0000 : good_q;
   wire [13:0] good_inc  = (good_base + 14'h0001 == GOOD_WRAP) ?
                           14'h0000 : good_base + 14'h0001;
   wire [7:0]  bad_base  = rd_bad ? 8'h00 : bad_q;

   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_RX]   = med_frame_end_in;
   assign ev[IRQ_BAD]  = bad_evt;
   assign ev[IRQ_DONE] = auto_stop;

   wire [DW-1:0] rd_mux =
      (addr_in == CTRL_OFS)  ? {ctrl_q[15], run_q, ctrl_q[13:0]} :
      (addr_in == LEN_OFS)   ? {5'h00, len_q} :
      (addr_in == GAP_OFS)   ? {8'h00, gap_q} :
      (addr_in == ADDR_OFS)  ? addr_q :
      (addr_in == PAT_OFS)   ? {7'h00, pat_q} :
      (addr_in == GOOD_OFS)  ? {rxflag_q, 1'b0, good_q} :
      (addr_in == BAD_OFS)   ? {8'h00, bad_q} :
      (addr_in == ISTAT_OFS) ? {13'h0000, istat_q} :
      (addr_in == IMASK_OFS) ? {13'h0000, imask_q} : 16'h0000;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q  <= 16'h0000;
         len_q   <= LEN_RST;
         gap_q   <= GAP_RST;
         addr_q  <= ADDR_RST;
         pat_q   <= {1'b0, PAT_RST};
         imask_q <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_in;
         end
         if (wr_len) begin
            len_q <= wdata_in[10:0];
         end
         if (wr_gap) begin
            gap_q <= wdata_in[7:0];
         end
         if (wr_addr) begin
            addr_q <= wdata_in;
         end
         if (wr_pat) begin
            pat_q <= wdata_in[8:0];
         end
         if (wr_imask) begin
            imask_q <= wdata_in[IRQ_W-1:0];
         end
      end
   end

   // Auto stop overrides a same-cycle write of the run bit
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         run_q    <= 1'b0;
         frames_q <= '0;
      end else begin
         if (auto_stop) begin
            run_q    <= 1'b0; // R4
            frames_q <= '0;
         end else begin
            if (wr_ctrl) begin
               run_q <= wdata_in[GEN_RUN_BIT];
            end
            if (run_start) begin
               frames_q <= '0;
            end else if (frame_done) begin
               frames_q <= frames_q + 25'h0000001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_q   <= GEN_IDLE;
         idx_q  <= '0;
         pace_q <= '0;
      end else begin
         st_q   <= st_d;
         idx_q  <= idx_d;
         pace_q <= (tick || st_q == GEN_IDLE) ? 8'h00 : pace_q + 8'h01;
      end
   end

   // Read clears first, so a frame in the read cycle still counts
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         good_q   <= '0;
         bad_q    <= '0;
         rxflag_q <= 1'b0;
         istat_q  <= '0;
      end else begin
         good_q <= good_evt ? good_inc : good_base;             // R6 R8 R9
         bad_q  <= (bad_evt && bad_base != BAD_MAX) ?
                   bad_base + 8'h01 : bad_base;                 // R6 R8 R10
         rxflag_q <= med_frame_end_in || (rxflag_q && !rd_good); // R7
         istat_q  <= ev | (rd_istat ? '0 : istat_q);
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out    <= '0;
         med_txd_out  <= '0;
         med_txen_out <= 1'b0;
         mac_rxd_out  <= '0;
         mac_rxdv_out <= 1'b0;
         irq_out      <= 1'b0;
      end else begin
         rdata_out    <= rd_in ? rd_mux : 16'h0000;
         med_txd_out  <= tx_d;
         med_txen_out <= tx_en;
         mac_rxd_out  <= rx_d;
         mac_rxdv_out <= rx_en;
         irq_out      <= |(ev | ((rd_istat ? '0 : istat_q))) &
                         |(imask_q & (ev | (rd_istat ? '0 : istat_q)));
      end
   end

   // Connector loopback speed comes from the normal control path
   assign speed_out    = spd;                   // R17
   assign conn_lb_out  = ctrl_q[CONN_BIT];
   assign swap_dis_out = ctrl_q[SWAP_BIT];

   near_silent_a: assert property ( // R16
      @(posedge clk_sys_in) disable iff (rst_in)
      near_lb |=> !med_txen_out)
      else $error("medium driven in near-end loopback");
   near_echo_a: assert property ( // R15
      @(posedge clk_sys_in) disable iff (rst_in)
      near_lb |=> mac_rxd_out == $past(mac_txd_in) &&
                  mac_rxdv_out == $past(mac_txen_in))
      else $error("near-end loopback data mismatch");
   far_echo_a: assert property ( // R12
      @(posedge clk_sys_in) disable iff (rst_in)
      far_lb && !near_lb |=> med_txd_out == $past(med_rxd_in) &&
                             med_txen_out == $past(med_rxdv_in))
      else $error("far-end loopback echo mismatch");
   far_mac_a: assert property ( // R13
      @(posedge clk_sys_in) disable iff (rst_in)
      far_lb && !near_lb && !rx_dis |=> mac_rxd_out == $past(med_rxd_in))
      else $error("far-end loopback lost receive data");
   gen_source_a: assert property ( // R1
      @(posedge clk_sys_in) disable iff (rst_in)
      gen_en && !near_lb && !far_lb |=> med_txen_out == $past(gen_txen))
      else $error("generator not the transmit source");
   rx_disable_a: assert property ( // R2
      @(posedge clk_sys_in) disable iff (rst_in)
      !near_lb && rx_dis |=> !mac_rxdv_out)
      else $error("receive not silenced");
   good_wrap_a: assert property ( // R9
      @(posedge clk_sys_in) disable iff (rst_in)
      good_q == GOOD_WRAP - 14'h0001 && good_evt && !rd_good |=> good_q == 0)
      else $error("good counter did not wrap");
   bad_sat_a: assert property ( // R10
      @(posedge clk_sys_in) disable iff (rst_in)
      bad_q == BAD_MAX && !rd_bad |=> bad_q == BAD_MAX)
      else $error("bad counter left saturation");
   read_clear_a: assert property ( // R8
      @(posedge clk_sys_in) disable iff (rst_in)
      rd_good && !med_frame_end_in |=> good_q == 0 && !rxflag_q &&
                                      rdata_out[13:0] == $past(good_q))
      else $error("good counter read did not clear");
   auto_stop_a: assert property ( // R4
      @(posedge clk_sys_in) disable iff (rst_in)
      auto_stop |=> !run_q ##1 st_q != GEN_HDR)
      else $error("generator did not stop");
   gen_data_a: assert property ( // R1
      @(posedge clk_sys_in) disable iff (rst_in)
      gen_en && !near_lb && !far_lb |=> med_txd_out == $past(gen_txd))
      else $error("generator byte not on the medium");
   gen_rx_live_a: assert property ( // R2
      @(posedge clk_sys_in) disable iff (rst_in)
      gen_en && !near_lb && !rx_dis |=> mac_rxd_out == $past(med_rxd_in) &&
                                        mac_rxdv_out == $past(med_rxdv_in))
      else $error("receive silenced by the generator");
   gen_start_a: assert property ( // R3
      @(posedge clk_sys_in) disable iff (rst_in)
      st_q == GEN_IDLE && gen_en && run_q |=> st_q == GEN_HDR)
      else $error("run bit did not start a frame");
   good_count_a: assert property ( // R6
      @(posedge clk_sys_in) disable iff (rst_in)
      good_evt && !rd_good && good_q != GOOD_WRAP - 14'h0001 |=>
         good_q == $past(good_q) + 14'h0001)
      else $error("good frame not counted");
   bad_count_a: assert property ( // R6
      @(posedge clk_sys_in) disable iff (rst_in)
      bad_evt && !rd_bad && bad_q != BAD_MAX |=>
         bad_q == $past(bad_q) + 8'h01)
      else $error("bad frame not counted");
   flag_set_a: assert property ( // R7
      @(posedge clk_sys_in) disable iff (rst_in)
      med_frame_end_in |=> rxflag_q)
      else $error("frame-received flag not set");
   good_only_a: assert property ( // R7
      @(posedge clk_sys_in) disable iff (rst_in)
      good_evt && !rd_bad |=> bad_q == $past(bad_q))
      else $error("good frame reached the bad counter");
   bad_only_a: assert property ( // R7
      @(posedge clk_sys_in) disable iff (rst_in)
      bad_evt && !rd_good |=> good_q == $past(good_q))
      else $error("bad frame reached the good counter");
   bad_clear_a: assert property ( // R8
      @(posedge clk_sys_in) disable iff (rst_in)
      rd_bad && !med_frame_end_in |=> bad_q == 8'h00 &&
                                     rdata_out[7:0] == $past(bad_q))
      else $error("bad counter read did not clear");
endmodule // ptl_test_top

/* hdl/ptl_pkg.sv */
// Constants and types for the port test, loopback and frame check block
package ptl_pkg;
   localparam int          DW           = 16;
   localparam int          AW           = 4;
   // Register offsets
   localparam logic [3:0]  CTRL_OFS     = 4'h0;
   localparam logic [3:0]  LEN_OFS      = 4'h1;
   localparam logic [3:0]  GAP_OFS      = 4'h2;
   localparam logic [3:0]  ADDR_OFS     = 4'h3;
   localparam logic [3:0]  PAT_OFS      = 4'h4;
   localparam logic [3:0]  GOOD_OFS     = 4'h5;
   localparam logic [3:0]  BAD_OFS      = 4'h6;
   localparam logic [3:0]  ISTAT_OFS    = 4'h7;
   localparam logic [3:0]  IMASK_OFS    = 4'h8;
   // Control field positions
   localparam int          GEN_EN_BIT   = 15;
   localparam int          GEN_RUN_BIT  = 14;
   localparam int          CONT_BIT     = 13;
   localparam int          RXDIS_BIT    = 10;
   localparam int          NEAR_BIT     = 9;
   localparam int          FAR_BIT      = 8;
   localparam int          CONN_BIT     = 7;
   localparam int          SWAP_BIT     = 6;
   localparam int          SPD_LSB      = 0;
   localparam int          PAT_BAD_BIT  = 8;
   localparam int          RXFLAG_BIT   = 15;
   // Reset values
   localparam logic [10:0] LEN_RST      = 11'h02E;
   localparam logic [7:0]  GAP_RST      = 8'h0C;
   localparam logic [15:0] ADDR_RST     = 16'h0000;
   localparam logic [7:0]  PAT_RST      = 8'hA5;
   // Counter limits
   localparam logic [13:0] GOOD_WRAP    = 14'h2710;
   localparam logic [7:0]  BAD_MAX      = 8'hFF;
   localparam int          FRAME_LIMIT_DEF = 30000000;
   // Line speeds and byte times
   localparam logic [1:0]  SPD_10       = 2'h0;
   localparam logic [1:0]  SPD_100      = 2'h1;
   localparam int          CLK_NS       = 5;
   localparam int          BYTE_NS_1000 = 8;
   localparam int          BYTE_NS_100  = 80;
   localparam int          BYTE_NS_10   = 800;
   localparam int          CYC_1000 = (BYTE_NS_1000 + CLK_NS - 1) / CLK_NS;
   localparam int          CYC_100  = (BYTE_NS_100 + CLK_NS - 1) / CLK_NS;
   localparam int          CYC_10   = (BYTE_NS_10 + CLK_NS - 1) / CLK_NS;
   // Generated frame layout
   localparam logic [10:0] HDR_LEN      = 11'h00C;
   localparam logic [10:0] ADDR_LEN     = 11'h006;
   localparam logic [10:0] FCS_LEN      = 11'h004;
   localparam logic [7:0]  FCS_BYTE     = 8'hC7;
   // Interrupt status bits
   localparam int          IRQ_RX       = 0;
   localparam int          IRQ_BAD      = 1;
   localparam int          IRQ_DONE     = 2;
   localparam int          IRQ_W        = 3;
   typedef enum logic [2:0] {
      GEN_IDLE, GEN_HDR, GEN_PAY, GEN_FCS, GEN_GAP
   } ptl_gen_e;
endpackage

/* sim/ptl_link_model.sv */
// Media-side link partner model: sends frames on request
`timescale 1ns/1ps
module ptl_link_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       go_in,
   input  wire logic       ok_in,
   input  wire logic [7:0] len_in,
   input  wire logic [7:0] byte_in,
   output logic [7:0]      rxd_out,
   output logic            rxdv_out,
   output logic            end_out,
   output logic            crc_ok_out,
   output logic            busy_out
);
   logic [7:0] cnt_q;
   logic [7:0] rxd_q;
   logic       ok_q;
   // Idle lines show inverted values so stale data never looks valid
   assign rxd_out    = rxdv_out ? rxd_q : ~rxd_q;
   assign crc_ok_out = end_out ? ok_q : ~ok_q;
   assign busy_out   = (cnt_q != 8'h00);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q    <= 8'h00;
         rxd_q    <= 8'h00;
         ok_q     <= 1'b0;
         rxdv_out <= 1'b0;
         end_out  <= 1'b0;
      end else begin
         rxdv_out <= busy_out;
         end_out  <= (cnt_q == 8'h01);
         if (busy_out) begin
            rxd_q <= byte_in;
            cnt_q <= cnt_q - 8'h01;
         end else if (go_in) begin
            cnt_q <= len_in;
            ok_q  <= ok_in;
         end
      end
   end
endmodule // ptl_link_model

/* sim/test_phy_test_loopback_crc_gen.sv */
// Self-checking bench for the port test, loopback and counter block
`timescale 1ns/1ps
module test_phy_test_loopback_crc_gen
   import ptl_pkg::*;
();
   logic          clk_sys_in, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic [AW-1:0] addr_in = 4'h0;
   logic [DW-1:0] wdata_in = 16'h0000, rdata_out, rv, ctl = 16'h0000;
   logic [15:0]   g_addr, g_pat;
   logic [10:0]   g_len;
   logic [7:0]    mac_txd_in = 8'h00, mac_rxd_out, med_rxd_in, med_txd_out;
   logic [7:0]    rnd_b = 8'h00, flen = 8'h00, p_mtxd, p_rxd, e_d;
   logic [1:0]    speed_out, spd;
   logic          mac_txen_in = 1'b0, mac_rxdv_out, med_rxdv_in, med_end;
   logic          med_ok, med_txen_out, conn_lb_out, swap_dis_out, irq_out;
   logic          go = 1'b0, ok = 1'b0, busy, p_mtxen, p_rxdv, e_v, gb;
   logic          path_chk = 1'b0, gen_mon = 1'b0;
   // Last mode: generator enabled but not running, MAC noise must not leak
   logic [15:0]   modes [7] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300,
                                16'h0400, 16'h0500, 16'h8000};
   int            n_mismatch = 0, num_checks = 0, gen_cyc = 0, hold = 1;
   int            ng, nb, i, k;
   integer        seed = 32'h0D95FBA9;

   ptl_test_top #(.FRAME_LIMIT(3)) u_dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .irq_out(irq_out), .mac_txd_in(mac_txd_in),
      .mac_txen_in(mac_txen_in), .mac_rxd_out(mac_rxd_out),
      .mac_rxdv_out(mac_rxdv_out), .med_rxd_in(med_rxd_in),
      .med_rxdv_in(med_rxdv_in), .med_frame_end_in(med_end),
      .med_crc_ok_in(med_ok), .med_txd_out(med_txd_out),
      .med_txen_out(med_txen_out), .speed_out(speed_out),
      .conn_lb_out(conn_lb_out), .swap_dis_out(swap_dis_out));
   ptl_link_model u_link (
      .clk_in(clk_sys_in), .rst_in(rst_in), .go_in(go), .ok_in(ok),
      .len_in(flen), .byte_in(rnd_b), .rxd_out(med_rxd_in),
      .rxdv_out(med_rxdv_in), .end_out(med_end), .crc_ok_out(med_ok),
      .busy_out(busy));

   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // MAC side keeps sending noise so any leak onto a path shows
   always @(posedge clk_sys_in) begin
      mac_txd_in  <= 8'($random(seed));
      mac_txen_in <= 1'($random(seed));
      rnd_b       <= 8'($random(seed));
      p_mtxd      <= mac_txd_in;
      p_mtxen     <= mac_txen_in;
      p_rxd       <= med_rxd_in;
      p_rxdv      <= med_rxdv_in;
   end

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      wr_in    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in   <= 1'b0;
      @(negedge clk_sys_in);
      d = rdata_out;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      rd(a, rv);
      chk(rv, e);
   endtask
   task automatic frame(input logic good, input logic [7:0] len);
      int n;
      @(posedge clk_sys_in);
      go   <= 1'b1;
      ok   <= good;
      flen <= len;
      @(posedge clk_sys_in);
      go <= 1'b0;
      n = 0;
      @(negedge clk_sys_in);
      while (busy && n < 400) begin
         @(negedge clk_sys_in);
         n++;
      end
      if (busy) begin
         n_mismatch++;
         results();
      end
   endtask
   function automatic logic [7:0] gen_byte(input int b);
      if (b < int'(ADDR_LEN)) return g_addr[15:8];
      if (b < int'(HDR_LEN)) return g_addr[7:0];
      if (b < int'(HDR_LEN) + int'(g_len)) return g_pat[7:0];
      return g_pat[PAT_BAD_BIT] ? ~FCS_BYTE : FCS_BYTE;
   endfunction

   always @(negedge clk_sys_in) begin
      if (path_chk) begin
         e_v = ctl[NEAR_BIT] ? 1'b0 : ctl[FAR_BIT] ? p_rxdv :
               ctl[GEN_EN_BIT] ? 1'b0 : p_mtxen;
         chk(16'(med_txen_out), 16'(e_v));
         if (e_v) begin
            e_d = ctl[FAR_BIT] ? p_rxd : p_mtxd;
            chk(16'(med_txd_out), 16'(e_d));
         end
         e_v = ctl[NEAR_BIT] ? p_mtxen : ctl[RXDIS_BIT] ? 1'b0 : p_rxdv;
         chk(16'(mac_rxdv_out), 16'(e_v));
         if (e_v) begin
            e_d = ctl[NEAR_BIT] ? p_mtxd : p_rxd;
            chk(16'(mac_rxd_out), 16'(e_d));
         end
      end
      if (gen_mon && med_txen_out) begin
         if (gen_cyc % hold == 0) begin
            e_d = gen_byte(gen_cyc / hold % (16 + int'(g_len)));
            chk(16'(med_txd_out), 16'(e_d));
         end
         gen_cyc++;
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      wr(4'hF, 16'hFFFF);
      rd_chk(CTRL_OFS, 16'h0000);
      rd_chk(LEN_OFS, {5'h00, LEN_RST});
      rd_chk(GAP_OFS, {8'h00, GAP_RST});
      rd_chk(ADDR_OFS, ADDR_RST);
      rd_chk(PAT_OFS, {8'h00, PAT_RST});
      rd_chk(4'hF, 16'h0000);
      for (k = 0; k < 7; k++) begin
         ctl = modes[k];
         wr(CTRL_OFS, ctl);
         repeat (3) @(posedge clk_sys_in);
         path_chk = 1'b1;
         frame(1'b1, 8'h0C);
         frame(1'b0, 8'h05);
         path_chk = 1'b0;
      end
      rd(GOOD_OFS, rv);
      rd(BAD_OFS, rv);
      rd(ISTAT_OFS, rv);
      wr(IMASK_OFS, 16'h0001);
      ng = 0;
      nb = 0;
      for (i = 0; i < 20; i++) begin
         gb = 1'($random(seed));
         frame(gb, 8'(1 + i % 4));
         if (gb) ng++;
         else nb++;
      end
      repeat (3) @(negedge clk_sys_in);
      chk(16'(irq_out), 16'h0001);
      rd_chk(ISTAT_OFS, {13'h0000, 1'b0, nb != 0, 1'b1});
      repeat (2) @(negedge clk_sys_in);
      chk(16'(irq_out), 16'h0000);
      rd_chk(GOOD_OFS, 16'h8000 | 16'(ng));
      rd_chk(BAD_OFS, 16'(nb));
      rd_chk(GOOD_OFS, 16'h0000);
      rd_chk(BAD_OFS, 16'h0000);
      wr(IMASK_OFS, 16'h0000);
      for (i = 0; i < 257; i++) frame(1'b0, 8'h01);
      chk(16'(irq_out), 16'h0000);
      rd_chk(BAD_OFS, {8'h00, BAD_MAX});
      for (i = 0; i < 10002; i++) frame(1'b1, 8'h01);
      rd_chk(GOOD_OFS, 16'h8002);
      wr(CTRL_OFS, 16'h0082);
      wr(CTRL_OFS, 16'h00C2);
      @(negedge clk_sys_in);
      chk({12'h000, speed_out, conn_lb_out, swap_dis_out}, 16'h000B);
      // Near-end first keeps the medium quiet while reconfiguring
      wr(CTRL_OFS, 16'h0200);
      for (k = 0; k < 3; k++) begin
         g_len  = 11'(1 + ($random(seed) & 3));
         g_addr = 16'($random(seed));
         g_pat  = 16'($random(seed)) & 16'h01FF;
         hold   = k == 0 ? 2 : k == 1 ? 16 : 160;
         spd    = k == 0 ? 2'h2 : k == 1 ? SPD_100 : SPD_10;
         wr(LEN_OFS, {5'h00, g_len});
         wr(GAP_OFS, 16'h0002);
         wr(ADDR_OFS, g_addr);
         wr(PAT_OFS, g_pat);
         rd(ISTAT_OFS, rv);
         gen_cyc = 0;
         gen_mon = 1'b1;
         wr(CTRL_OFS, 16'hC000 | 16'(spd));
         rv = 16'hFFFF;
         i = 0;
         while (rv[GEN_RUN_BIT] && i < 9000) begin
            rd(CTRL_OFS, rv);
            i++;
         end
         if (rv[GEN_RUN_BIT]) begin
            n_mismatch++;
            results();
         end
         repeat (4) @(negedge clk_sys_in);
         chk(16'(gen_cyc), 16'(3 * (16 + int'(g_len)) * hold));
         rd_chk(ISTAT_OFS, 16'h0004);
         gen_mon = 1'b0;
      end
      results();
   end
endmodule // test_phy_test_loopback_crc_gen
